// ===== include/utb_pkg.sv
// Package with register map, field positions and reset values of the time base
package utb_pkg;

  // Bus and datapath widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned IRQ_N = 2;

  // Register byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_PRIMARY_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EVENT_GENERATION = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT_VALUE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DIVIDER_SETTING = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RELOAD_LIMIT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h20;

  // Field positions in primary_control_reg
  localparam int unsigned CTRL_COUNT_ENABLE_BIT = 0;
  localparam int unsigned CTRL_UPDATE_SUPPRESS_BIT = 1;
  localparam int unsigned CTRL_UPDATE_REQUEST_SOURCE_BIT = 2;
  localparam int unsigned CTRL_RELOAD_BUFFERING_ENABLE_BIT = 7;

  // Field positions in flag, event and interrupt registers
  localparam int unsigned FLAG_UPDATE_INTERRUPT_BIT = 0;
  localparam int unsigned EVGEN_UPDATE_GENERATE_BIT = 0;
  localparam int unsigned IRQ_UPDATE_BIT = 0;
  localparam int unsigned IRQ_OVERFLOW_BIT = 1;

  // Reset values
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] RELOAD_RST = 16'h0000;
  localparam logic [CNT_W-1:0] DIVIDER_RST = 16'h0000;
  localparam logic [IRQ_N-1:0] IRQ_RST = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

endpackage

// ===== include/utb_link_if.sv
// Interface joining the time base core to its prescaler and interrupt logic
`timescale 1ns/10ps
interface utb_link_if;
  // Prescaler control and tick
  logic div_en;
  logic div_clear;
  logic div_load;
  logic [utb_pkg::CNT_W-1:0] div_setting;
  logic div_tick;
  logic [utb_pkg::CNT_W-1:0] div_count;
  logic [utb_pkg::CNT_W-1:0] div_ratio;
  // Interrupt events and registers
  logic [utb_pkg::IRQ_N-1:0] irq_set;
  logic irq_en_wr;
  logic irq_clr_wr;
  logic [utb_pkg::IRQ_N-1:0] irq_wdata;
  logic [utb_pkg::IRQ_N-1:0] irq_status;
  logic [utb_pkg::IRQ_N-1:0] irq_enable;
  logic irq_line;

  modport core (
    output div_en, div_clear, div_load, div_setting,
    input div_tick, div_count, div_ratio,
    output irq_set, irq_en_wr, irq_clr_wr, irq_wdata,
    input irq_status, irq_enable, irq_line
  );
  modport div (
    input div_en, div_clear, div_load, div_setting,
    output div_tick, div_count, div_ratio
  );
  modport irq (
    input irq_set, irq_en_wr, irq_clr_wr, irq_wdata,
    output irq_status, irq_enable, irq_line
  );
endinterface

// ===== hdl/utb_prescaler.sv
// Buffered 16-bit prescaler producing the counter tick enable
`timescale 1ns/10ps
module utb_prescaler (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  utb_link_if.div lnk
);

  logic [utb_pkg::CNT_W-1:0] ratio_q;
  logic [utb_pkg::CNT_W-1:0] count_q;

  // Active ratio only changes at an update event, so writes never glitch a period
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ratio_q <= utb_pkg::DIVIDER_RST;
    end else if (lnk.div_load) begin
      ratio_q <= lnk.div_setting;
    end
  end

  // Inner counter runs 0..ratio, so ratio 0 divides by 1 and ffff by 65536
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= utb_pkg::COUNT_RST;
    end else if (lnk.div_clear) begin
      count_q <= utb_pkg::COUNT_RST;
    end else if (lnk.div_en) begin
      count_q <= (count_q == ratio_q) ? utb_pkg::COUNT_RST : count_q + 16'h0001;
    end
  end

  // Tick is gated by the enable
  assign lnk.div_tick = lnk.div_en && (count_q == ratio_q);
  assign lnk.div_count = count_q;
  assign lnk.div_ratio = ratio_q;

  AST_TICK_GATED: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !lnk.div_en |-> !lnk.div_tick)
    else $error("tick without count enable");

  AST_RATIO_LOAD: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !lnk.div_load |=> $stable(ratio_q))
    else $error("prescale ratio changed outside update event");

endmodule // utb_prescaler

// ===== hdl/utb_irq.sv
// Sticky interrupt status, enable mask and level interrupt line
`timescale 1ns/10ps
module utb_irq (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  utb_link_if.irq lnk
);

  logic [utb_pkg::IRQ_N-1:0] status_q;
  logic [utb_pkg::IRQ_N-1:0] enable_q;
  logic line_q;

  // One sticky bit per event; a new event beats a clear in the same cycle
  for (genvar i = 0; i < utb_pkg::IRQ_N; i++) begin : g_stat
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        status_q[i] <= 1'b0;
      end else if (lnk.irq_set[i]) begin
        status_q[i] <= 1'b1;
      end else if (lnk.irq_clr_wr && lnk.irq_wdata[i]) begin
        status_q[i] <= 1'b0;
      end
    end
  end

  // Enable mask
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_q <= utb_pkg::IRQ_RST;
    end else if (lnk.irq_en_wr) begin
      enable_q <= lnk.irq_wdata;
    end
  end

  // Registered line, one cycle behind the status it reflects
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_q <= 1'b0;
    end else begin
      line_q <= |(status_q & enable_q);
    end
  end

  assign lnk.irq_status = status_q;
  assign lnk.irq_enable = enable_q;
  assign lnk.irq_line = line_q;

  AST_IRQ_LEVEL: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    |(status_q & enable_q) |=> line_q)
    else $error("interrupt line low while enabled status set");

endmodule // utb_irq

// ===== hdl/utb_time_base.sv
// Time-base unit: up-counter, buffered reload limit, buffered prescaler
`timescale 1ns/10ps
module utb_time_base (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [utb_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [utb_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [utb_pkg::DATA_W-1:0] reg_rdata_o,
  output logic irq_o,
  output logic update_event_o
);

  utb_link_if lnk ();

  // Control bits of primary_control_reg
  logic count_enable_q;
  logic update_suppress_q;
  logic update_request_source_q;
  logic reload_buffering_enable_q;

  // Counter, reload copies and divider setting
  logic [utb_pkg::CNT_W-1:0] count_q;
  logic [utb_pkg::CNT_W-1:0] reload_pre_q;
  logic [utb_pkg::CNT_W-1:0] reload_pre_d;
  logic [utb_pkg::CNT_W-1:0] reload_shadow_q;
  logic [utb_pkg::CNT_W-1:0] divider_setting_q;

  // Flags and outputs
  logic update_interrupt_flag_q;
  logic update_event_q;
  logic [utb_pkg::DATA_W-1:0] rdata_q;
  logic [utb_pkg::DATA_W-1:0] rd_val;

  // Decoded strobes and events
  logic wr_ctrl;
  logic wr_flag;
  logic wr_evgen;
  logic wr_count;
  logic wr_div;
  logic wr_reload;
  logic update_generate;
  logic tick;
  logic overflow;
  logic update_event;
  logic uif_set;
  logic uif_clear;

  // Address decode of write strobes
  assign wr_ctrl = reg_wr_i && (reg_addr_i == utb_pkg::OFS_PRIMARY_CONTROL);
  assign wr_flag = reg_wr_i && (reg_addr_i == utb_pkg::OFS_FLAG_STATUS);
  assign wr_evgen = reg_wr_i && (reg_addr_i == utb_pkg::OFS_EVENT_GENERATION);
  assign wr_count = reg_wr_i && (reg_addr_i == utb_pkg::OFS_COUNT_VALUE);
  assign wr_div = reg_wr_i && (reg_addr_i == utb_pkg::OFS_DIVIDER_SETTING);
  assign wr_reload = reg_wr_i && (reg_addr_i == utb_pkg::OFS_RELOAD_LIMIT);

  // Software update request, a pulse in the write cycle only
  assign update_generate = wr_evgen &&
    reg_wdata_i[utb_pkg::EVGEN_UPDATE_GENERATE_BIT];

  // Tick from the prescaler
  assign tick = lnk.div_tick;

  // Overflow at the limit; a software update or count write in the same cycle wins
  assign overflow = tick && !update_generate && !wr_count &&
    (count_q == reload_shadow_q);

  // Update event from overflow or software, blocked while suppressed
  assign update_event = !update_suppress_q &&
    (overflow || update_generate);

  // Flag is skipped when software asked with request source set
  assign uif_set = update_event &&
    !(update_generate && update_request_source_q);
  assign uif_clear = wr_flag &&
    !reg_wdata_i[utb_pkg::FLAG_UPDATE_INTERRUPT_BIT];

  // Preload value as it stands after this cycle's write
  assign reload_pre_d = wr_reload ? reg_wdata_i[utb_pkg::CNT_W-1:0] : reload_pre_q;

  // Control register; the enable flop feeds the prescaler, hence one cycle latency
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_enable_q <= 1'b0;
      update_suppress_q <= 1'b0;
      update_request_source_q <= 1'b0;
      reload_buffering_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      count_enable_q <= reg_wdata_i[utb_pkg::CTRL_COUNT_ENABLE_BIT];
      update_suppress_q <= reg_wdata_i[utb_pkg::CTRL_UPDATE_SUPPRESS_BIT];
      update_request_source_q <= reg_wdata_i[utb_pkg::CTRL_UPDATE_REQUEST_SOURCE_BIT];
      reload_buffering_enable_q <= reg_wdata_i[utb_pkg::CTRL_RELOAD_BUFFERING_ENABLE_BIT];
    end
  end

  // Main counter: software update first, then a direct write, then counting
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= utb_pkg::COUNT_RST;
    end else if (update_generate) begin
      count_q <= utb_pkg::COUNT_RST;
    end else if (wr_count) begin
      count_q <= reg_wdata_i[utb_pkg::CNT_W-1:0];
    end else if (overflow) begin
      count_q <= utb_pkg::COUNT_RST;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Reload preload copy, the only one software sees
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_pre_q <= utb_pkg::RELOAD_RST;
    end else begin
      reload_pre_q <= reload_pre_d;
    end
  end

  // Shadow follows the preload unbuffered, else only at update events
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_shadow_q <= utb_pkg::RELOAD_RST;
    end else if (!reload_buffering_enable_q || update_event) begin
      reload_shadow_q <= reload_pre_d;
    end
  end

  // Divider setting; the active copy lives in the prescaler
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      divider_setting_q <= utb_pkg::DIVIDER_RST;
    end else if (wr_div) begin
      divider_setting_q <= reg_wdata_i[utb_pkg::CNT_W-1:0];
    end
  end

  // Update interrupt flag; a hardware set beats a software clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      update_interrupt_flag_q <= 1'b0;
    end else if (uif_set) begin
      update_interrupt_flag_q <= 1'b1;
    end else if (uif_clear) begin
      update_interrupt_flag_q <= 1'b0;
    end
  end

  // Registered copy of the update event for the outside world
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      update_event_q <= 1'b0;
    end else begin
      update_event_q <= update_event;
    end
  end

  // Prescaler hookup; a software update clears it even when suppressed
  assign lnk.div_en = count_enable_q;
  assign lnk.div_clear = update_generate;
  assign lnk.div_load = update_event;
  assign lnk.div_setting = divider_setting_q;

  // Interrupt events and register strobes
  assign lnk.irq_set[utb_pkg::IRQ_UPDATE_BIT] = uif_set;
  assign lnk.irq_set[utb_pkg::IRQ_OVERFLOW_BIT] = overflow;
  assign lnk.irq_en_wr = reg_wr_i && (reg_addr_i == utb_pkg::OFS_IRQ_ENABLE);
  assign lnk.irq_clr_wr = reg_wr_i && (reg_addr_i == utb_pkg::OFS_IRQ_CLEAR);
  assign lnk.irq_wdata = reg_wdata_i[utb_pkg::IRQ_N-1:0];

  utb_prescaler u_prescaler (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .lnk(lnk.div)
  );

  utb_irq u_irq (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .lnk(lnk.irq)
  );

  // Read mux; write-only registers and unmapped addresses read zero
  always_comb begin
    rd_val = utb_pkg::RDATA_RST;
    case (reg_addr_i)
      utb_pkg::OFS_PRIMARY_CONTROL: begin
        rd_val[utb_pkg::CTRL_COUNT_ENABLE_BIT] = count_enable_q;
        rd_val[utb_pkg::CTRL_UPDATE_SUPPRESS_BIT] = update_suppress_q;
        rd_val[utb_pkg::CTRL_UPDATE_REQUEST_SOURCE_BIT] = update_request_source_q;
        rd_val[utb_pkg::CTRL_RELOAD_BUFFERING_ENABLE_BIT] = reload_buffering_enable_q;
      end
      utb_pkg::OFS_FLAG_STATUS: begin
        rd_val[utb_pkg::FLAG_UPDATE_INTERRUPT_BIT] = update_interrupt_flag_q;
      end
      utb_pkg::OFS_COUNT_VALUE: begin
        rd_val[utb_pkg::CNT_W-1:0] = count_q;
      end
      utb_pkg::OFS_DIVIDER_SETTING: begin
        rd_val[utb_pkg::CNT_W-1:0] = divider_setting_q;
      end
      utb_pkg::OFS_RELOAD_LIMIT: begin
        rd_val[utb_pkg::CNT_W-1:0] = reload_pre_q;
      end
      utb_pkg::OFS_IRQ_STATUS: begin
        rd_val[utb_pkg::IRQ_N-1:0] = lnk.irq_status;
      end
      utb_pkg::OFS_IRQ_ENABLE: begin
        rd_val[utb_pkg::IRQ_N-1:0] = lnk.irq_enable;
      end
      default: begin
        rd_val = utb_pkg::RDATA_RST;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= utb_pkg::RDATA_RST;
    end else if (reg_rd_i) begin
      rdata_q <= rd_val;
    end else begin
      rdata_q <= utb_pkg::RDATA_RST;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o = lnk.irq_line;
  assign update_event_o = update_event_q;

  // Counter wraps to zero after reaching the limit
  AST_CNT_WRAP: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    overflow |=> (count_q == utb_pkg::COUNT_RST) && update_event_q == !$past(update_suppress_q))
    else $error("counter did not wrap at the reload limit");

  // Counter steps by one on an ordinary tick
  AST_CNT_STEP: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    tick && !overflow && !update_generate && !wr_count
    |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter did not step by one");

  // Counter holds without a tick
  AST_CNT_HOLD: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !tick && !update_generate && !wr_count |=> $stable(count_q))
    else $error("counter moved without a tick");

  // With suppression and buffering both on, no update event and no shadow load
  AST_SUPPRESS: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    update_suppress_q && reload_buffering_enable_q
    |=> !update_event_q && $stable(reload_shadow_q))
    else $error("update event while suppressed");

  // Software update clears both counters even when suppressed
  AST_SW_CLEAR: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    update_generate |=> count_q == utb_pkg::COUNT_RST && lnk.div_count == utb_pkg::COUNT_RST)
    else $error("software update did not clear the counters");

  // Request source set keeps the flag low on a software update
  AST_URS_NOFLAG: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    update_generate && update_request_source_q && !update_interrupt_flag_q
    |=> !update_interrupt_flag_q)
    else $error("flag set by software update with request source set");

  // Flag sets on a flagged update event
  AST_UIF_SET: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    uif_set |=> update_interrupt_flag_q ##1 $past(update_event_q))
    else $error("update flag not set by update event");

  // Flag stays until software writes zero
  AST_UIF_STICKY: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    update_interrupt_flag_q && !uif_clear |=> update_interrupt_flag_q)
    else $error("update flag dropped without software clear");

  // Unbuffered reload write reaches the shadow in the next cycle
  AST_RELOAD_DIRECT: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_reload && !reload_buffering_enable_q
    |=> reload_shadow_q == $past(reg_wdata_i[utb_pkg::CNT_W-1:0]))
    else $error("unbuffered reload did not reach the shadow");

  // Buffered shadow changes only with an update event
  AST_RELOAD_BUF: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    reload_buffering_enable_q && !update_event |=> $stable(reload_shadow_q))
    else $error("buffered shadow changed outside update event");

  // Enable write reaches the prescaler one cycle later
  AST_START: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_ctrl && reg_wdata_i[utb_pkg::CTRL_COUNT_ENABLE_BIT] && lnk.div_ratio == 16'h0000
    && !count_enable_q |=> tick)
    else $error("counting did not start one cycle after enable");

endmodule // utb_time_base

// ===== dv/utb_time_base_test.sv
// Self-checking testbench of the time base: register access, counting, updates, interrupt
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); \
  end \
end

module utb_time_base_test;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [utb_pkg::ADDR_W-1:0] reg_addr_i = 8'h00;
  logic [utb_pkg::DATA_W-1:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [utb_pkg::DATA_W-1:0] reg_rdata_o;
  logic irq_o;
  logic update_event_o;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 32'h099d029f;
  int i;
  int ta, t0, t1, t2, t3, ts;
  logic rd_q = 1'b0;
  logic [31:0] v, w, e_v;
  logic [7:0] a_v;
  logic [31:0] exp_q[$];
  logic [7:0] adr_q[$];

  utb_time_base utb_time_base_i (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o),
    .update_event_o(update_event_o)
  );

  // Free-running clock and cycle stamp
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;

  // Read monitor: data only stands in the cycle after the strobe, so sample exactly there
  always @(posedge mclk_i) begin
    rd_q <= reg_rd_i;
    if (rd_q) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("mismatch read queue expected entry seen none");
      end else begin
        a_v = adr_q.pop_front();
        e_v = exp_q.pop_front();
        `CHK($sformatf("read at %h", a_v), e_v, reg_rdata_o)
      end
    end
  end

  // Verdict and end of run
  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One-cycle write strobe; a spare edge between calls keeps strobes single-assigned
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  // One-cycle read strobe; expectation queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(e);
    adr_q.push_back(a);
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
  endtask

  // Bounded wait for an update pulse, returns its cycle stamp
  task automatic wait_uev(output int t);
    int k;
    for (k = 0; k < 400; k++) begin
      @(posedge mclk_i);
      if (update_event_o === 1'b1) break;
    end
    t = cyc;
    if (k == 400) begin
      n_errors++;
      $display("mismatch update pulse expected 1 seen timeout");
      test_done();
    end
  endtask

  // Interrupt line is registered, so let two edges pass before looking
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK("irq line", e, irq_o)
  endtask

  initial begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // Every register and one unmapped place read zero after reset
    for (i = 0; i < 10; i++) rd(8'(i * 4), 32'h0);
    // Random values with counting off; upper half reads zero
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      w = $random(seed);
      wr(utb_pkg::OFS_COUNT_VALUE, v);
      rd(utb_pkg::OFS_COUNT_VALUE, {16'h0000, v[15:0]});
      wr(utb_pkg::OFS_RELOAD_LIMIT, w);
      rd(utb_pkg::OFS_RELOAD_LIMIT, {16'h0000, w[15:0]});
      wr(utb_pkg::OFS_DIVIDER_SETTING, v ^ w);
      rd(utb_pkg::OFS_DIVIDER_SETTING, {16'h0000, v[15:0] ^ w[15:0]});
    end
    wr(utb_pkg::OFS_IRQ_STATUS, 32'h3);
    rd(utb_pkg::OFS_IRQ_STATUS, 32'h0);
    // Software update loads ratio 1, clears counter, raises flag and interrupt
    wr(utb_pkg::OFS_RELOAD_LIMIT, 32'h3);
    wr(utb_pkg::OFS_DIVIDER_SETTING, 32'h1);
    wr(utb_pkg::OFS_IRQ_ENABLE, 32'h1);
    wr(utb_pkg::OFS_EVENT_GENERATION, 32'h1);
    wait_uev(t0);
    rd(utb_pkg::OFS_FLAG_STATUS, 32'h1);
    rd(utb_pkg::OFS_COUNT_VALUE, 32'h0);
    chk_irq(1'b1);
    // Flag is sticky: writing one keeps it, only zero clears it
    wr(utb_pkg::OFS_FLAG_STATUS, 32'h1);
    rd(utb_pkg::OFS_FLAG_STATUS, 32'h1);
    wr(utb_pkg::OFS_FLAG_STATUS, 32'h0);
    rd(utb_pkg::OFS_FLAG_STATUS, 32'h0);
    rd(utb_pkg::OFS_IRQ_STATUS, 32'h1);
    wr(utb_pkg::OFS_IRQ_ENABLE, 32'h0);
    chk_irq(1'b0);
    wr(utb_pkg::OFS_IRQ_CLEAR, 32'h3);
    rd(utb_pkg::OFS_IRQ_STATUS, 32'h0);
    wr(utb_pkg::OFS_IRQ_ENABLE, 32'h1);
    // Request source set: pulse without flag
    wr(utb_pkg::OFS_PRIMARY_CONTROL, 32'h4);
    wr(utb_pkg::OFS_EVENT_GENERATION, 32'h1);
    wait_uev(t0);
    rd(utb_pkg::OFS_FLAG_STATUS, 32'h0);
    // Counting: limit 3, ratio 1 gives 8 cycles; new ratio 2 waits for the next update
    wr(utb_pkg::OFS_PRIMARY_CONTROL, 32'h1);
    wait_uev(ta);
    wait_uev(t0);
    `CHK("update period", 8, t0 - ta)
    wr(utb_pkg::OFS_DIVIDER_SETTING, 32'h2);
    wait_uev(t1);
    wait_uev(t2);
    `CHK("update period", 8, t1 - t0)
    `CHK("update period", 12, t2 - t1)
    rd(utb_pkg::OFS_FLAG_STATUS, 32'h1);
    chk_irq(1'b1);
    // Unbuffered limit acts at once; buffered limit waits one period
    wait_uev(t0);
    wr(utb_pkg::OFS_RELOAD_LIMIT, 32'h5);
    wait_uev(t1);
    `CHK("update period", 18, t1 - t0)
    wr(utb_pkg::OFS_PRIMARY_CONTROL, 32'h81);
    wr(utb_pkg::OFS_RELOAD_LIMIT, 32'h7);
    wait_uev(t2);
    wait_uev(t3);
    `CHK("update period", 18, t2 - t1)
    `CHK("update period", 24, t3 - t2)
    // Suppression blocks overflow events and the flag
    wr(utb_pkg::OFS_FLAG_STATUS, 32'h0);
    wr(utb_pkg::OFS_PRIMARY_CONTROL, 32'h83);
    repeat (60) begin
      @(posedge mclk_i);
      `CHK("update pulse", 1'b0, update_event_o)
    end
    rd(utb_pkg::OFS_FLAG_STATUS, 32'h0);
    // Suppressed software update still clears the counter, ratio kept
    wr(utb_pkg::OFS_PRIMARY_CONTROL, 32'h2);
    wr(utb_pkg::OFS_DIVIDER_SETTING, 32'h0);
    wr(utb_pkg::OFS_COUNT_VALUE, 32'h5);
    wr(utb_pkg::OFS_EVENT_GENERATION, 32'h1);
    repeat (4) begin
      @(posedge mclk_i);
      `CHK("update pulse", 1'b0, update_event_o)
    end
    rd(utb_pkg::OFS_COUNT_VALUE, 32'h0);
    // Start latency and kept ratio 2: eight counts of three from the enable edge, then one cycle for the registered pulse
    wr(utb_pkg::OFS_PRIMARY_CONTROL, 32'h1);
    ts = cyc;
    wait_uev(t0);
    `CHK("first pulse delay", 25, t0 - ts)
    wait_uev(t1);
    `CHK("update period", 8, t1 - t0)
    rd(utb_pkg::OFS_IRQ_STATUS, 32'h3);
    wr(utb_pkg::OFS_PRIMARY_CONTROL, 32'h0);
    // Restart with ratio 0: the first step lands one cycle after the enable write
    wr(utb_pkg::OFS_COUNT_VALUE, 32'h0);
    wr(utb_pkg::OFS_PRIMARY_CONTROL, 32'h1);
    rd(utb_pkg::OFS_COUNT_VALUE, 32'h1);
    wr(utb_pkg::OFS_PRIMARY_CONTROL, 32'h0);
    repeat (4) @(posedge mclk_i);
    test_done();
  end
endmodule // utb_time_base_test
